// file: core/arru_pkg.sv
// Package: constants, types and decoding for the result readout block
// Behaviour
// - Manual fetch by command, or automatic push
// - Read-data command sends latest finished result
// - Ready line falls on each new result not pushed automatically
// - Pin 2 shows ready only when routed
// - Readable status bit flags a new result
// - Late result never disturbs running transmission
// - Counter byte leads frames in both modes
// - Integrity bytes follow data bytes without gap
// - CRC16 field is exactly two bytes
// - Inverted field is three or four bytes
// - Five 8-bit registers, read/write by command
// - Reset clears every register to zero
// - Power-down keeps register contents
// - Words LSB byte first, bytes LSB first
// - Integrity field: off, inverted, CRC16, reserved
// - Status bit clears when data is read
package arru_pkg;
  // Register addresses
  localparam logic [2:0] REG_GAIN = 3'h0;
  localparam logic [2:0] REG_RATE = 3'h1;
  localparam logic [2:0] REG_STAT = 3'h2;
  localparam logic [2:0] REG_ROUTE = 3'h3;
  localparam logic [2:0] REG_PINS = 3'h4;
  localparam int REG_COUNT = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Writable bit masks; reserved bits read zero, status bit reads the ready flag
  localparam logic [7:0] WMASK_STAT = 8'h7F;
  localparam logic [7:0] WMASK_ROUTE = 8'hFD;
  localparam logic [7:0] WMASK_PINS = 8'h7F;
  localparam logic [7:0] WMASK_FULL = 8'hFF;
  // Field positions
  localparam int READY_BIT = 7;
  localparam int CNT_EN_BIT = 6;
  localparam int INTEG_LSB = 4;
  localparam int AUTO_BIT = 0;
  localparam int PIN2_DIR_BIT = 6;
  localparam int PIN2_SEL_BIT = 3;
  localparam int PIN2_DAT_BIT = 2;
  // Integrity select codes
  localparam logic [1:0] INTEG_OFF = 2'h0;
  localparam logic [1:0] INTEG_INV = 2'h1;
  localparam logic [1:0] INTEG_CRC = 2'h2;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  // Command bytes
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [6:0] OP_PDOWN = 7'h01;
  localparam logic [6:0] OP_RESET = 7'h03;
  localparam logic [6:0] OP_START = 7'h04;
  localparam logic [3:0] OP_RDATA = 4'h1;
  localparam logic [3:0] OP_REGISTER_READ_CMD = 4'h2;
  localparam logic [3:0] OP_REGISTER_WRITE_CMD = 4'h4;
  // Transmit timing
  localparam int CLK_HZ = 32'h05F5_E100;
  localparam int BAUD_RATE = 32'h0001_C200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int BAUD_W = 10;
  localparam logic [3:0] UART_BITS = 4'h9;
  // Command kinds
  typedef enum {CMD_NONE, CMD_RESET, CMD_START, CMD_PDOWN, CMD_RDATA, CMD_REGISTER_READ_CMD,
    CMD_REGISTER_WRITE_CMD} arru_cmd_type;
  // Command parser states
  typedef enum {P_SYNC, P_CMD, P_WDATA} arru_parse_type;

  // Classify one command byte
  function automatic arru_cmd_type arruDecode(input logic [7:0] b);
    arru_cmd_type k;
    k = CMD_NONE;
    if (b[7:1] == OP_RESET) k = CMD_RESET;
    else if (b[7:1] == OP_START) k = CMD_START;
    else if (b[7:1] == OP_PDOWN) k = CMD_PDOWN;
    else if (b[7:4] == OP_RDATA) k = CMD_RDATA;
    else if (b[7:4] == OP_REGISTER_READ_CMD) k = CMD_REGISTER_READ_CMD;
    else if (b[7:4] == OP_REGISTER_WRITE_CMD) k = CMD_REGISTER_WRITE_CMD;
    return k;
  endfunction : arruDecode
endpackage : arru_pkg

// file: core/arru_byte_if.sv
// Interface: byte stream with valid and ready
`timescale 1ns/1ps
interface arru_byte_if;
  logic [7:0] data; // Byte on offer
  logic valid; // Byte present
  logic ready; // Receiver takes it
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : arru_byte_if

// file: core/arru_byte_buffer.sv
// Two-entry byte buffer between frame builder and transmitter
`timescale 1ns/1ps
module arru_byte_buffer
  import arru_pkg::*;
(
  input logic clk,
  input logic rst,
  arru_byte_if.snk fill,
  arru_byte_if.src drain
);
  logic [7:0] mem_ff [2]; // Storage words
  logic wrPtr_ff; // Next write slot
  logic rdPtr_ff; // Next read slot
  logic [1:0] count_ff; // Words held
  logic wrFire; // Word accepted
  logic rdFire; // Word taken

  // Honest full and empty
  assign fill.ready = (count_ff != 2'h2);
  assign drain.valid = (count_ff != 2'h0);
  assign drain.data = mem_ff[rdPtr_ff];
  assign wrFire = fill.valid && fill.ready;
  assign rdFire = drain.valid && drain.ready;

  // Write side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ff[0] <= 8'h00;
      mem_ff[1] <= 8'h00;
      wrPtr_ff <= 1'b0;
    end else if (wrFire) begin
      mem_ff[wrPtr_ff] <= fill.data;
      wrPtr_ff <= !wrPtr_ff;
    end
  end

  // Read side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdPtr_ff <= 1'b0;
    else if (rdFire) rdPtr_ff <= !rdPtr_ff;
  end

  // Occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) count_ff <= 2'h0;
    else if (wrFire && !rdFire) count_ff <= count_ff + 2'h1;
    else if (rdFire && !wrFire) count_ff <= count_ff - 2'h1;
  end

  // Never overfilled
  a_buf_bound: assert property (@(posedge clk) disable iff (rst) count_ff <= 2'h2)
    else $error("buffer count out of range");
endmodule : arru_byte_buffer

// file: core/arru_result_uart.sv
// Result readout, register file and 8-N-1 transmitter of the converter
`timescale 1ns/1ps
module arru_result_uart
  import arru_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic convDone,
  input logic [23:0] convData,
  input logic [7:0] rxData,
  input logic rxValid,
  output logic rxReady,
  output logic txPin,
  output logic resultReadyN,
  output logic pin2Out,
  output logic pin2Oe,
  output logic powerDown,
  output logic startPulse
);
  arru_byte_if bufIn (); // Frame builder to buffer
  arru_byte_if bufOut (); // Buffer to transmitter

  logic [7:0] cfgRegs_ff [REG_COUNT]; // Configuration registers
  logic resultReady_ff; // New result flag
  logic [23:0] resultData_ff; // Latest finished result
  logic [7:0] convCount_ff; // Conversion counter
  arru_parse_type pState_ff; // Command parser state
  logic [2:0] wrAddr_ff; // Address held for write
  logic [63:0] frameVec_ff; // Bytes of current frame
  logic [3:0] frameLen_ff; // Bytes in current frame
  logic [3:0] emitIdx_ff; // Next byte to push
  logic emitBusy_ff; // Frame being pushed
  logic pin2Out_ff; // Pin 2 level
  logic powerDown_ff; // Power-down state
  logic startPulse_ff; // Start request
  logic txBusy_ff; // Character in flight
  logic [8:0] txShift_ff; // Data and stop bits left
  logic [3:0] txBits_ff; // Bits still to send
  logic [BAUD_W-1:0] baudCnt_ff; // Bit period counter
  logic txPin_ff; // Line level

  logic rxFire; // Byte accepted
  arru_cmd_type cmdKind; // Kind of command byte
  logic rdataFire; // Read-data command
  logic rregFire; // Register read command
  logic wregFire; // Register write data byte
  logic resetFire; // Reset command
  logic autoMode; // Automatic push selected
  logic cntEn; // Counter byte enabled
  logic [1:0] integSel; // Integrity option
  logic autoLoad; // Push a fresh result
  logic frameLoad; // New frame taken
  logic [23:0] srcData; // Result for new frame
  logic [7:0] srcCnt; // Counter for new frame
  logic [63:0] nxtFrame; // Bytes for new frame
  logic [3:0] nxtLen; // Length of new frame
  logic [2:0] baseLen; // Counter plus data bytes
  logic [15:0] crcVal; // Check word
  logic baudTick; // End of one bit

  // Writable mask per address
  function automatic logic [7:0] wmask(input logic [2:0] a);
    case (a)
      REG_STAT: wmask = WMASK_STAT;
      REG_ROUTE: wmask = WMASK_ROUTE;
      REG_PINS: wmask = WMASK_PINS;
      default: wmask = WMASK_FULL;
    endcase
  endfunction : wmask

  // CRC16 over the first n bytes, each byte high bit first
  function automatic logic [15:0] crc16(input logic [31:0] v, input logic [2:0] n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int b = 0; b < 4; b++) begin
      if (3'(b) < n) begin
        c = c ^ {v[8*b +: 8], 8'h00};
        for (int i = 0; i < 8; i++) begin
          c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
      end
    end
    return c;
  endfunction : crc16

  // Configuration fields steering the block
  assign autoMode = cfgRegs_ff[REG_ROUTE][AUTO_BIT];
  assign cntEn = cfgRegs_ff[REG_STAT][CNT_EN_BIT];
  assign integSel = cfgRegs_ff[REG_STAT][INTEG_LSB +: 2];

  // Commands wait while a frame is being pushed
  assign rxReady = !emitBusy_ff;
  assign rxFire = rxValid && rxReady;
  assign cmdKind = arruDecode(rxData);
  assign rdataFire = rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_RDATA);
  assign rregFire = rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_REGISTER_READ_CMD);
  assign resetFire = rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_RESET);
  assign wregFire = rxFire && (pState_ff == P_WDATA);

  // Automatic push when idle and no command frame this cycle
  assign autoLoad = autoMode && convDone && !emitBusy_ff && !rdataFire && !rregFire;
  assign frameLoad = rdataFire || rregFire || autoLoad;

  // Parser: sync byte, command, optional data byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pState_ff <= P_SYNC;
      wrAddr_ff <= 3'h0;
    end else if (rxFire) begin
      case (pState_ff)
        P_SYNC: begin
          if (rxData == SYNC_BYTE) pState_ff <= P_CMD;
        end
        P_CMD: begin
          wrAddr_ff <= rxData[3:1];
          pState_ff <= (cmdKind == CMD_REGISTER_WRITE_CMD) ? P_WDATA : P_SYNC;
        end
        P_WDATA: pState_ff <= P_SYNC;
        default: pState_ff <= P_SYNC;
      endcase
    end
  end

  // Register file; power-down leaves it untouched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < REG_COUNT; r++) cfgRegs_ff[r] <= REG_RESET;
    end else if (resetFire) begin
      for (int r = 0; r < REG_COUNT; r++) cfgRegs_ff[r] <= REG_RESET;
    end else if (wregFire && (int'(wrAddr_ff) < REG_COUNT)) begin
      cfgRegs_ff[wrAddr_ff] <= rxData & wmask(wrAddr_ff);
    end
  end

  // Power state and start request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerDown_ff <= 1'b0;
      startPulse_ff <= 1'b0;
    end else begin
      startPulse_ff <= rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_START);
      if (resetFire) powerDown_ff <= 1'b0;
      else if (rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_PDOWN)) powerDown_ff <= 1'b1;
      else if (rxFire && (pState_ff == P_CMD) && (cmdKind == CMD_START)) powerDown_ff <= 1'b0;
    end
  end

  // Latest result and counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultData_ff <= 24'h00_0000;
      convCount_ff <= 8'h00;
    end else if (resetFire) begin
      resultData_ff <= 24'h00_0000;
      convCount_ff <= 8'h00;
    end else if (convDone) begin
      resultData_ff <= convData;
      convCount_ff <= convCount_ff + 8'h01;
    end
  end

  // Status flag: a new result wins over a same-cycle manual read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) resultReady_ff <= 1'b0;
    else if (resetFire) resultReady_ff <= 1'b0;
    else if (convDone && !autoLoad) resultReady_ff <= 1'b1;
    else if (autoLoad || rdataFire) resultReady_ff <= 1'b0;
  end

  // Ready line is the inverted status flag
  assign resultReadyN = !resultReady_ff;

  // Pin 2: ready line only when driven and routed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pin2Out_ff <= 1'b0;
    else if (cfgRegs_ff[REG_PINS][PIN2_SEL_BIT]) pin2Out_ff <= resultReadyN;
    else pin2Out_ff <= cfgRegs_ff[REG_PINS][PIN2_DAT_BIT];
  end
  assign pin2Out = pin2Out_ff;
  assign pin2Oe = cfgRegs_ff[REG_PINS][PIN2_DIR_BIT];

  // Fresh result in automatic mode, stored one otherwise
  assign srcData = autoLoad ? convData : resultData_ff;
  assign srcCnt = autoLoad ? (convCount_ff + 8'h01) : convCount_ff;
  assign baseLen = cntEn ? 3'h4 : 3'h3;

  // Build the frame bytes, first byte in the low lane
  always_comb begin
    nxtFrame = 64'h0000_0000_0000_0000;
    nxtLen = 4'h0;
    crcVal = 16'h0000;
    if (rregFire) begin
      nxtFrame[7:0] = (int'(rxData[3:1]) < REG_COUNT) ? cfgRegs_ff[rxData[3:1]] : 8'h00;
      if (rxData[3:1] == REG_STAT) nxtFrame[READY_BIT] = resultReady_ff;
      nxtLen = 4'h1;
    end else begin
      if (cntEn) nxtFrame[31:0] = {srcData, srcCnt};
      else nxtFrame[31:0] = {8'h00, srcData};
      nxtLen = {1'b0, baseLen};
      crcVal = crc16(nxtFrame[31:0], baseLen);
      case (integSel)
        INTEG_INV: begin
          for (int b = 0; b < 4; b++) begin
            if (3'(b) < baseLen) nxtFrame[8*(int'(baseLen)+b) +: 8] = ~nxtFrame[8*b +: 8];
          end
          nxtLen = {baseLen, 1'b0};
        end
        INTEG_CRC: begin
          nxtFrame[8*int'(baseLen) +: 16] = crcVal;
          nxtLen = {1'b0, baseLen} + 4'h2;
        end
        default: nxtLen = {1'b0, baseLen};
      endcase
    end
  end

  // Frame pusher; a newer result waits for the next load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameVec_ff <= 64'h0000_0000_0000_0000;
      frameLen_ff <= 4'h0;
      emitIdx_ff <= 4'h0;
      emitBusy_ff <= 1'b0;
    end else if (frameLoad) begin
      frameVec_ff <= nxtFrame;
      frameLen_ff <= nxtLen;
      emitIdx_ff <= 4'h0;
      emitBusy_ff <= 1'b1;
    end else if (emitBusy_ff && bufIn.ready) begin
      emitIdx_ff <= emitIdx_ff + 4'h1;
      if (emitIdx_ff == frameLen_ff - 4'h1) emitBusy_ff <= 1'b0;
    end
  end
  assign bufIn.valid = emitBusy_ff;
  assign bufIn.data = frameVec_ff[8*emitIdx_ff +: 8];

  // Two-entry buffer absorbs transmitter stalls
  arru_byte_buffer uBuffer (
    .clk(clk),
    .rst(rst),
    .fill(bufIn.snk),
    .drain(bufOut.src)
  );

  // Transmitter takes a byte only when idle
  assign bufOut.ready = !txBusy_ff;
  assign baudTick = (baudCnt_ff == BAUD_W'(BIT_CYCLES - 1));

  // Bit period counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) baudCnt_ff <= '0;
    else if (!txBusy_ff || baudTick) baudCnt_ff <= '0;
    else baudCnt_ff <= baudCnt_ff + BAUD_W'(1);
  end

  // Start bit, eight data bits LSB first, stop bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txBusy_ff <= 1'b0;
      txShift_ff <= 9'h1FF;
      txBits_ff <= 4'h0;
      txPin_ff <= 1'b1;
    end else if (!txBusy_ff) begin
      if (bufOut.valid) begin
        txBusy_ff <= 1'b1;
        txShift_ff <= {1'b1, bufOut.data};
        txBits_ff <= UART_BITS;
        txPin_ff <= 1'b0;
      end
    end else if (baudTick) begin
      if (txBits_ff == 4'h0) begin
        txBusy_ff <= 1'b0;
      end else begin
        txPin_ff <= txShift_ff[0];
        txShift_ff <= {1'b1, txShift_ff[8:1]};
        txBits_ff <= txBits_ff - 4'h1;
      end
    end
  end

  assign txPin = txPin_ff;
  assign powerDown = powerDown_ff;
  assign startPulse = startPulse_ff;

  // Checks; counter setting taken from the load cycle, a write may land with it
  a_auto_push: assert property (@(posedge clk) disable iff (rst)
    (autoMode && convDone && !emitBusy_ff && !rregFire && !rdataFire) |=>
    emitBusy_ff && frameVec_ff[8*int'($past(cntEn)) +: 24] == $past(convData))
    else $error("automatic frame missing");
  a_rdata_load: assert property (@(posedge clk) disable iff (rst)
    (rdataFire && !cntEn) |=> frameVec_ff[23:0] == $past(resultData_ff))
    else $error("read-data frame has wrong result");
  a_ready_fall: assert property (@(posedge clk) disable iff (rst)
    (convDone && !autoMode && !resetFire) |=> !resultReadyN && resultReady_ff)
    else $error("ready line did not fall");
  a_pin2_route: assert property (@(posedge clk) disable iff (rst)
    (pin2Oe && cfgRegs_ff[REG_PINS][PIN2_SEL_BIT]) |=> pin2Out == $past(resultReadyN))
    else $error("pin 2 not showing ready");
  a_status_clear: assert property (@(posedge clk) disable iff (rst)
    (rdataFire && !convDone) |=> !resultReady_ff ##1 (resultReady_ff == $past(convDone)))
    else $error("status not cleared by read");
  a_frame_stable: assert property (@(posedge clk) disable iff (rst)
    emitBusy_ff |=> $stable(frameVec_ff))
    else $error("frame changed during transmission");
  a_crc_len: assert property (@(posedge clk) disable iff (rst)
    (frameLoad && !rregFire && integSel == INTEG_CRC) |=>
    frameLen_ff == ($past(cntEn) ? 4'h6 : 4'h5))
    else $error("CRC field not two bytes");
  a_inv_len: assert property (@(posedge clk) disable iff (rst)
    (frameLoad && !rregFire && integSel == INTEG_INV) |=>
    frameLen_ff == ($past(cntEn) ? 4'h8 : 4'h6))
    else $error("inverted field wrong length");
  a_reg_reset: assert property (@(posedge clk) disable iff (rst)
    resetFire |=> cfgRegs_ff[REG_STAT] == REG_RESET && cfgRegs_ff[REG_ROUTE] == REG_RESET)
    else $error("registers not cleared");
  a_pd_hold: assert property (@(posedge clk) disable iff (rst)
    (powerDown_ff && !wregFire && !resetFire) |=> $stable(cfgRegs_ff[REG_RATE]))
    else $error("register changed in power-down");
  a_tx_start: assert property (@(posedge clk) disable iff (rst)
    $rose(txBusy_ff) |-> !txPin ##1 (!txPin)[*8])
    else $error("start bit too short");

  c_auto_frame: cover property (@(posedge clk) disable iff (rst) autoLoad);
  c_rdata_crc: cover property (@(posedge clk) disable iff (rst)
    rdataFire && integSel == INTEG_CRC);
  c_reg_write: cover property (@(posedge clk) disable iff (rst) wregFire);
  c_buffer_full: cover property (@(posedge clk) disable iff (rst) emitBusy_ff && !bufIn.ready);
endmodule : arru_result_uart

// file: test/arru_host_model.sv
// Host model: command sender and 8-N-1 receiver on the transmit line
`timescale 1ns/1ps
module arru_host_model
  import arru_pkg::*;
(
  input logic clk,
  input logic txPin,
  input logic rxReady,
  output logic [7:0] rxData,
  output logic rxValid
);
  logic [7:0] gotQ[$]; // Bytes heard on the transmit line
  int stuckCount = 0; // Offers never taken or bad stop bits

  // Idle command line at time zero
  initial begin
    rxData = 8'hAA;
    rxValid = 1'b0;
  end

  // Offer one byte, hold it until taken, then release
  task automatic sendByte(input logic [7:0] b);
    int n;
    logic ok;
    n = 0;
    @(negedge clk);
    rxData = b;
    rxValid = 1'b1;
    do begin
      #1 ok = (rxReady === 1'b1);
      @(posedge clk);
      n++;
    end while (!ok && n < 2000);
    if (!ok) stuckCount++;
    @(negedge clk);
    rxValid = 1'b0;
    rxData = ~b; // Released line shows no stale byte
  endtask : sendByte

  // Sync byte ahead of every command
  task automatic command(input logic [7:0] op);
    sendByte(SYNC_BYTE);
    sendByte(op);
  endtask : command

  // Sample each character at mid-bit, LSB first
  initial begin
    logic [7:0] b;
    #100;
    forever begin
      @(negedge txPin);
      #(BIT_CYCLES * 15);
      for (int i = 0; i < 8; i++) begin
        b[i] = txPin;
        #(BIT_CYCLES * 10);
      end
      if (txPin !== 1'b1) stuckCount++; // Missing stop bit
      gotQ.push_back(b);
    end
  end
endmodule : arru_host_model

// file: test/adc_result_readout_uart_tb_top.sv
// Testbench: register access, manual and automatic result frames
`timescale 1ns/1ps
module adc_result_readout_uart_tb_top
  import arru_pkg::*;
;
  logic clk; // 100 MHz clock
  logic rst; // Async reset, active high
  logic convDone; // Conversion finished pulse
  logic [23:0] convData; // Conversion result
  logic [7:0] rxData;
  logic rxValid, rxReady, txPin, resultReadyN, pin2Out, pin2Oe, powerDown, startPulse;
  int n_mismatch = 0; // Mismatches seen
  int comparisons = 0; // Comparisons made
  int nStart = 0; // Start pulses seen
  logic [7:0] exp[$]; // Expected frame bytes
  logic [15:0] crc; // Expected check word

  arru_result_uart i_arru_result_uart (
    .clk(clk), .rst(rst), .convDone(convDone), .convData(convData), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txPin(txPin), .resultReadyN(resultReadyN),
    .pin2Out(pin2Out), .pin2Oe(pin2Oe), .powerDown(powerDown), .startPulse(startPulse)
  );

  arru_host_model i_arru_host_model (
    .clk(clk), .txPin(txPin), .rxReady(rxReady), .rxData(rxData), .rxValid(rxValid)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count start pulses where they have settled
  always @(negedge clk) begin
    if (startPulse === 1'b1) nStart++;
  end

  // Compare and report
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // Verdict and end of run
  task automatic end_of_test;
    chk(24'(i_arru_host_model.stuckCount), 24'h00_0000);
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Wait for the expected bytes, bounded, then compare in order
  task automatic expectFrame;
    int n;
    n = 0;
    while (i_arru_host_model.gotQ.size() < exp.size() && n < 100000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100000) begin
      n_mismatch++;
      end_of_test();
    end else begin
      foreach (exp[i]) chk(24'(i_arru_host_model.gotQ[i]), 24'(exp[i]));
      i_arru_host_model.gotQ.delete();
      exp.delete();
    end
  endtask : expectFrame

  // Register write: command with address, then data
  task automatic writeReg(input logic [2:0] a, input logic [7:0] d);
    i_arru_host_model.command({OP_REGISTER_WRITE_CMD, a, 1'b0});
    i_arru_host_model.sendByte(d);
  endtask : writeReg

  // Register read: one byte answer
  task automatic readReg(input logic [2:0] a, input logic [7:0] want);
    i_arru_host_model.command({OP_REGISTER_READ_CMD, a, 1'b0});
    exp.push_back(want);
    expectFrame();
  endtask : readReg

  // One conversion result pulse
  task automatic convert(input logic [23:0] d);
    @(negedge clk);
    convDone = 1'b1;
    convData = d;
    @(negedge clk);
    convDone = 1'b0;
    convData = ~d;
  endtask : convert

  // Check word over a 32-bit stream, MSB bit first
  function automatic logic [15:0] crcOf(input logic [31:0] w);
    logic [15:0] c;
    c = CRC_INIT;
    for (int k = 31; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crcOf

  // Main sequence
  initial begin
    rst = 1'b1;
    convDone = 1'b0;
    convData = 24'h00_0000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk({pin2Oe, powerDown, resultReadyN, txPin}, 24'h00_0003);
    // Pin 2 as output carrying the ready line
    writeReg(REG_PINS, 8'h48);
    repeat (2) @(negedge clk);
    chk({pin2Oe, pin2Out}, 24'h00_0003);
    // Power-down then start; pin setup must survive
    i_arru_host_model.command({OP_PDOWN, 1'b0});
    repeat (2) @(negedge clk);
    chk(powerDown, 24'h00_0001);
    i_arru_host_model.command({OP_START, 1'b0});
    repeat (2) @(negedge clk);
    chk({powerDown, pin2Oe}, 24'h00_0001);
    chk(24'(nStart), 24'h00_0001);
    // New result: ready falls, status readable
    convert(24'hA1_B2C3);
    chk(resultReadyN, 24'h00_0000);
    repeat (2) @(negedge clk);
    chk(pin2Out, 24'h00_0000);
    readReg(REG_STAT, 8'h80);
    // Manual fetch; a later result lands mid-frame
    i_arru_host_model.command({OP_RDATA, 4'h0});
    repeat (4) @(negedge clk);
    chk(resultReadyN, 24'h00_0001);
    convert(24'h5D_6E7F);
    exp = {8'hC3, 8'hB2, 8'hA1};
    expectFrame();
    chk(resultReadyN, 24'h00_0000);
    // Unmapped address reads zero
    readReg(3'h5, 8'h00);
    // Automatic push with counter and CRC16; host stays quiet meanwhile
    writeReg(REG_STAT, 8'h60);
    writeReg(REG_ROUTE, 8'h01);
    repeat (10) @(negedge clk);
    convert(24'h12_3456);
    crc = crcOf({8'h03, 8'h56, 8'h34, 8'h12});
    exp = {8'h03, 8'h56, 8'h34, 8'h12, crc[7:0], crc[15:8]};
    expectFrame();
    chk(txPin, 24'h00_0001);
    // Reset command clears pin setup and mode
    i_arru_host_model.command({OP_RESET, 1'b0});
    repeat (2) @(negedge clk);
    chk({pin2Oe, pin2Out, powerDown, resultReadyN}, 24'h00_0001);
    // Inverted field in automatic mode; its length is checked at the load
    writeReg(REG_STAT, 8'h10);
    writeReg(REG_ROUTE, 8'h01);
    convert(24'h9A_BCDE);
    repeat (2) @(negedge clk);
    chk(rxReady, 24'h00_0000);
    end_of_test();
  end
endmodule : adc_result_readout_uart_tb_top
